/* File: rhs_pkg.sv */
// Shared constants of the health supervisor: register map, field
// positions, counts and timing.
// Assumes a 200 MHz clock and a 32-bit APB register bus.
package rhs_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_HZ        = 200_000_000;
  localparam int unsigned TICK_PERIOD_MS = 1000;
  localparam int unsigned TICK_CYC      = CLK_HZ / 1000 * TICK_PERIOD_MS;
  localparam int unsigned TICK_W        = 28;
  localparam int unsigned HOST_TMO_S    = 30;
  localparam logic [4:0]  HOST_TMO      = 5'(HOST_TMO_S);
  localparam logic [7:0]  ALIVE_WRAP    = 8'hff;

  // ****************************************************************
  // Region sizes, in words
  // ****************************************************************
  localparam logic [6:0] N_DI   = 7'h04;
  localparam logic [6:0] N_DO   = 7'h02;
  localparam logic [6:0] N_AI   = 7'h08;
  localparam logic [6:0] N_RIO  = 7'h02;
  localparam logic [6:0] N_GW   = 7'h20;
  localparam logic [6:0] N_CALC = 7'h14;
  localparam int unsigned FUSE_N = 4;

  // ****************************************************************
  // Byte addresses
  // ****************************************************************
  localparam logic [11:0] A_STATUS   = 12'h000;
  localparam logic [11:0] A_ALIVE    = 12'h004;
  localparam logic [11:0] A_HOST_HB  = 12'h008;
  localparam logic [11:0] A_IRQ_STAT = 12'h00c;
  localparam logic [11:0] A_IRQ_MASK = 12'h010;
  localparam logic [11:0] A_DI       = 12'h100;
  localparam logic [11:0] A_DO       = 12'h140;
  localparam logic [11:0] A_AI       = 12'h180;
  localparam logic [11:0] A_RIO_IN   = 12'h200;
  localparam logic [11:0] A_RIO_OUT  = 12'h240;
  localparam logic [11:0] A_GW_IN    = 12'h300;
  localparam logic [11:0] A_GW_OUT   = 12'h380;
  localparam logic [11:0] A_CALC     = 12'h400;

  // ****************************************************************
  // Status word and interrupt bits
  // ****************************************************************
  localparam int unsigned ST_W    = 10;
  localparam int unsigned ST_CPU  = 0;
  localparam int unsigned ST_MOD  = 1;
  localparam int unsigned ST_RIO0 = 2;
  localparam int unsigned ST_RDN  = 4;
  localparam int unsigned ST_SER  = 5;
  localparam int unsigned ST_ONL  = 6;
  localparam int unsigned ST_WET  = 7;
  localparam int unsigned ST_FUSE = 8;
  localparam int unsigned ST_RUN  = 9;

  localparam int unsigned IRQ_W    = 7;
  localparam int unsigned IRQ_CPU  = 0;
  localparam int unsigned IRQ_MOD  = 1;
  localparam int unsigned IRQ_RIO  = 2;
  localparam int unsigned IRQ_SER  = 3;
  localparam int unsigned IRQ_OFFL = 4;
  localparam int unsigned IRQ_WET  = 5;
  localparam int unsigned IRQ_FUSE = 6;

  typedef enum logic [1:0] {
    ST_CLR_FLT = 2'h0,
    ST_CLR_CTL = 2'h1,
    ST_RUN_OK  = 2'h3,
    ST_FAILED  = 2'h2
  } rhs_state_e;

endpackage

/* File: rhs_tick_if.sv */
// Carrier between the supervisor core and its one-second divider.
// Assumes both ends sit on the same clock.
`timescale 1ns/100ps
interface rhs_tick_if;
  logic run;
  logic tick;
  modport src (input run, output tick);
  modport snk (output run, input tick);
endinterface

/* File: rhs_sec_tick.sv */
// One-second enable divider for the health supervisor.
// Assumes run comes from a flop of the core; counting restarts when
// run drops, so the first tick is a full period after run rises.
`timescale 1ns/100ps
module rhs_sec_tick #(
  parameter int unsigned TICK_CYC = rhs_pkg::TICK_CYC
) (
  input  wire logic clk,
  input  wire logic srst,
  rhs_tick_if.src   tk
);

  typedef struct packed {
    logic [rhs_pkg::TICK_W-1:0] cnt;
    logic                       tick;
  } rhs_tick_s;

  rhs_tick_s q;
  rhs_tick_s d;

  always_comb begin
    d      = q;
    d.tick = 1'b0;
    if (!tk.run) begin
      d.cnt = '0;
    end else if (q.cnt == rhs_pkg::TICK_W'(TICK_CYC - 1)) begin
      d.cnt  = '0;
      d.tick = 1'b1;
    end else begin
      d.cnt = q.cnt + rhs_pkg::TICK_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tk.tick = q.tick;

endmodule

/* File: rhs_supervisor.sv */
// Health supervisor core: start-up sequencing, diagnostics, alive
// counter, host heartbeat watch and the shared I/O memory map on APB.
// Assumes field inputs are synchronous to clk and that the APB master
// and gateway equipment share the same slave port.
//
// Implementation choices: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps

// Overview of operation
// - Start-up reaches run state without intervention
// - Fault registers zeroed before diagnostics start
// - Report cpu, module, remote link, serial faults
// - Alive counter steps each second, wraps after 255
// - Heartbeat unchanged thirty seconds means host offline
// - First output contact closed only while host online
// - First input point senses wetting voltage
// - Fuse alarms from second to fifth input points
// - No control output energised during start-up
// - Control memory cleared before outputs are enabled
// - Separate memory region per I/O class
// - Local inputs block-copied every scan
// - Remote I/O moved only on data change
// - Twenty calculation words reserved
// - Remote link and redundancy kept in status
module rhs_supervisor #(
  parameter int unsigned TICK_CYC = rhs_pkg::TICK_CYC
) (
  input  wire logic                     clk,
  input  wire logic                     srst,
  input  wire logic [11:0]              paddr,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire logic                     cpu_fault,
  input  wire logic                     module_fault,
  input  wire logic [1:0]               rio_link_ok,
  input  wire logic                     rio_redund_ok,
  input  wire logic                     serial_link_ok,
  input  wire logic [3:0][31:0]         di_in,
  input  wire logic [7:0][15:0]         ai_in,
  input  wire logic [1:0][31:0]         rio_in,
  output logic      [31:0]              do_mod0_out,
  output logic      [31:0]              do_mod1_out,
  output logic      [1:0][31:0]         rio_out,
  output logic      [1:0]               rio_out_stb,
  output logic                          outputs_live,
  output logic                          irq
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    rhs_pkg::rhs_state_e                      st;
    logic [7:0]                               alive;
    logic [31:0]                              host_hb;
    logic [4:0]                               tmo;
    logic                                     offline;
    logic [rhs_pkg::ST_W-1:0]                 diag;
    logic [rhs_pkg::IRQ_W-1:0]                irq_stat;
    logic [rhs_pkg::IRQ_W-1:0]                irq_mask;
    logic [rhs_pkg::N_DI-1:0][31:0]           di;
    logic [rhs_pkg::N_DO-1:0][31:0]           do_w;
    logic [rhs_pkg::N_DO-1:0][31:0]           do_drv;
    logic [rhs_pkg::N_AI-1:0][15:0]           ai;
    logic [rhs_pkg::N_RIO-1:0][31:0]          rio_in;
    logic [rhs_pkg::N_RIO-1:0][31:0]          rio_mem;
    logic [rhs_pkg::N_RIO-1:0][31:0]          rio_drv;
    logic [rhs_pkg::N_RIO-1:0]                rio_stb;
    logic [rhs_pkg::N_GW-1:0][31:0]           gw_in;
    logic [rhs_pkg::N_GW-1:0][31:0]           gw_out;
    logic [rhs_pkg::N_CALC-1:0][31:0]         calc;
    logic [31:0]                              rdata;
  } rhs_state_s;

  rhs_state_s q;
  rhs_state_s d;

  logic        hit;
  logic [31:0] rd;
  logic [5:0]  ix;
  logic        wr_en;
  logic        hb_chg;
  logic        run;
  logic        diag_on;
  logic [rhs_pkg::IRQ_W-1:0] ev;
  logic [7:0]  alive_w;
  logic [31:0] di0_w;

  rhs_tick_if tick_if ();

  rhs_sec_tick #(
    .TICK_CYC (TICK_CYC)
  ) u_tick (
    .clk  (clk),
    .srst (srst),
    .tk   (tick_if)
  );

  assign tick_if.run = (q.st == rhs_pkg::ST_RUN_OK);

  function automatic logic [5:0] widx(input logic [11:0] a,
                                      input logic [11:0] b);
    logic [11:0] o;
    o    = a - b;
    widx = o[7:2];
  endfunction

  function automatic logic in_rgn(input logic [11:0] a,
                                  input logic [11:0] b,
                                  input logic [6:0]  n);
    logic [11:0] o;
    o      = a - b;
    in_rgn = (a >= b) && (o[11:2] < {3'h0, n}) && (o[1:0] == 2'h0);
  endfunction

  // ****************************************************************
  // Read decode, one region per I/O class
  // ****************************************************************
  always_comb begin
    hit = 1'b1;
    rd  = '0;
    ix  = 6'h00;
    if (paddr == rhs_pkg::A_STATUS) begin
      rd = 32'(q.diag);
    end else if (paddr == rhs_pkg::A_ALIVE) begin
      rd = {24'h000000, q.alive};
    end else if (paddr == rhs_pkg::A_HOST_HB) begin
      rd = q.host_hb;
    end else if (paddr == rhs_pkg::A_IRQ_STAT) begin
      rd = 32'(q.irq_stat);
    end else if (paddr == rhs_pkg::A_IRQ_MASK) begin
      rd = 32'(q.irq_mask);
    end else if (in_rgn(paddr, rhs_pkg::A_DI, rhs_pkg::N_DI)) begin
      ix = widx(paddr, rhs_pkg::A_DI);
      rd = q.di[ix[1:0]];
    end else if (in_rgn(paddr, rhs_pkg::A_DO, rhs_pkg::N_DO)) begin
      ix = widx(paddr, rhs_pkg::A_DO);
      rd = q.do_w[ix[0]];
    end else if (in_rgn(paddr, rhs_pkg::A_AI, rhs_pkg::N_AI)) begin
      ix = widx(paddr, rhs_pkg::A_AI);
      rd = {16'h0000, q.ai[ix[2:0]]};
    end else if (in_rgn(paddr, rhs_pkg::A_RIO_IN, rhs_pkg::N_RIO)) begin
      ix = widx(paddr, rhs_pkg::A_RIO_IN);
      rd = q.rio_in[ix[0]];
    end else if (in_rgn(paddr, rhs_pkg::A_RIO_OUT, rhs_pkg::N_RIO)) begin
      ix = widx(paddr, rhs_pkg::A_RIO_OUT);
      rd = q.rio_mem[ix[0]];
    end else if (in_rgn(paddr, rhs_pkg::A_GW_IN, rhs_pkg::N_GW)) begin
      ix = widx(paddr, rhs_pkg::A_GW_IN);
      rd = q.gw_in[ix[4:0]];
    end else if (in_rgn(paddr, rhs_pkg::A_GW_OUT, rhs_pkg::N_GW)) begin
      ix = widx(paddr, rhs_pkg::A_GW_OUT);
      rd = q.gw_out[ix[4:0]];
    end else if (in_rgn(paddr, rhs_pkg::A_CALC, rhs_pkg::N_CALC)) begin
      ix = widx(paddr, rhs_pkg::A_CALC);
      rd = q.calc[ix[4:0]];
    end else begin
      hit = 1'b0;
    end
  end

  assign wr_en   = psel && penable && pwrite && hit;
  assign hb_chg  = wr_en && (paddr == rhs_pkg::A_HOST_HB) &&
                   (pwdata != q.host_hb);
  assign run     = (q.st == rhs_pkg::ST_RUN_OK);
  assign diag_on = run || (q.st == rhs_pkg::ST_FAILED);

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    d       = q;
    ev      = '0;
    d.rio_stb = '0;
    if (psel && !penable) begin
      d.rdata = rd;
    end

    // Start-up: faults first, then control memory, then run
    case (q.st)
      rhs_pkg::ST_CLR_FLT: begin
        d.diag     = '0;
        d.irq_stat = '0;
        d.st       = rhs_pkg::ST_CLR_CTL;
      end
      rhs_pkg::ST_CLR_CTL: begin
        d.do_w    = '0;
        d.rio_mem = '0;
        d.gw_out  = '0;
        d.st      = rhs_pkg::ST_RUN_OK;
      end
      rhs_pkg::ST_RUN_OK: begin
        if (cpu_fault) begin
          d.st = rhs_pkg::ST_FAILED;
        end
      end
      default: begin
        // Failed stays put until reset: no automatic re-arm of outputs
        d.st = rhs_pkg::ST_FAILED;
      end
    endcase

    // Diagnostics and scan copy
    if (diag_on) begin
      d.di = di_in;
      d.ai = ai_in;
      d.diag[rhs_pkg::ST_CPU]  = cpu_fault;
      d.diag[rhs_pkg::ST_MOD]  = module_fault;
      d.diag[rhs_pkg::ST_RIO0 +: 2] = rio_link_ok;
      d.diag[rhs_pkg::ST_RDN]  = rio_redund_ok;
      d.diag[rhs_pkg::ST_SER]  = serial_link_ok;
      d.diag[rhs_pkg::ST_ONL]  = !q.offline;
      d.diag[rhs_pkg::ST_WET]  = di_in[0][0];
      d.diag[rhs_pkg::ST_FUSE] = |di_in[0][rhs_pkg::FUSE_N:1];
      d.diag[rhs_pkg::ST_RUN]  = run;
      ev[rhs_pkg::IRQ_CPU]  = cpu_fault;
      ev[rhs_pkg::IRQ_MOD]  = module_fault;
      ev[rhs_pkg::IRQ_RIO]  = !(&rio_link_ok) || !rio_redund_ok;
      ev[rhs_pkg::IRQ_SER]  = !serial_link_ok;
      ev[rhs_pkg::IRQ_OFFL] = q.offline;
      ev[rhs_pkg::IRQ_WET]  = !di_in[0][0];
      ev[rhs_pkg::IRQ_FUSE] = |di_in[0][rhs_pkg::FUSE_N:1];
      // Remote I/O moves only when its data differs
      for (int i = 0; i < rhs_pkg::N_RIO; i++) begin
        if (rio_link_ok[i] && (rio_in[i] != q.rio_in[i])) begin
          d.rio_in[i] = rio_in[i];
        end
      end
    end

    // Alive counter and host heartbeat watch
    if (run && tick_if.tick) begin
      if (q.alive == rhs_pkg::ALIVE_WRAP) begin
        d.alive = '0;
      end else begin
        d.alive = q.alive + 8'h01;
      end
      if (q.tmo != rhs_pkg::HOST_TMO) begin
        d.tmo = q.tmo + 5'h01;
      end
    end
    if (!run) begin
      d.tmo = '0;
    end else if (hb_chg) begin
      // A rewrite with the same value is no proof of life
      d.tmo = '0;
    end
    d.offline = (d.tmo == rhs_pkg::HOST_TMO);

    // Register writes; control memory only once running
    if (wr_en) begin
      if (paddr == rhs_pkg::A_HOST_HB) begin
        d.host_hb = pwdata;
      end else if (paddr == rhs_pkg::A_IRQ_STAT) begin
        d.irq_stat = q.irq_stat & ~pwdata[rhs_pkg::IRQ_W-1:0];
      end else if (paddr == rhs_pkg::A_IRQ_MASK) begin
        d.irq_mask = pwdata[rhs_pkg::IRQ_W-1:0];
      end else if (run && in_rgn(paddr, rhs_pkg::A_DO, rhs_pkg::N_DO)) begin
        d.do_w[ix[0]] = pwdata;
      end else if (run && in_rgn(paddr, rhs_pkg::A_RIO_OUT,
                                 rhs_pkg::N_RIO)) begin
        d.rio_mem[ix[0]] = pwdata;
      end else if (in_rgn(paddr, rhs_pkg::A_GW_IN, rhs_pkg::N_GW)) begin
        d.gw_in[ix[4:0]] = pwdata;
      end else if (run && in_rgn(paddr, rhs_pkg::A_GW_OUT,
                                 rhs_pkg::N_GW)) begin
        d.gw_out[ix[4:0]] = pwdata;
      end else if (in_rgn(paddr, rhs_pkg::A_CALC, rhs_pkg::N_CALC)) begin
        d.calc[ix[4:0]] = pwdata;
      end
    end
    // Set beats clear so no event is lost
    d.irq_stat = d.irq_stat | ev;

    // Output drive follows the next state, so outputs drop the same
    // edge that run is left
    if (d.st == rhs_pkg::ST_RUN_OK) begin
      d.do_drv    = d.do_w;
      d.do_drv[0][0] = !d.offline && !cpu_fault;
      for (int i = 0; i < rhs_pkg::N_RIO; i++) begin
        if (q.rio_drv[i] != q.rio_mem[i]) begin
          d.rio_drv[i] = q.rio_mem[i];
          d.rio_stb[i] = 1'b1;
        end
      end
    end else begin
      d.do_drv  = '0;
      d.rio_drv = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign prdata       = q.rdata;
  assign pready       = 1'b1;
  assign pslverr      = psel && penable && !hit;
  assign do_mod0_out  = q.do_drv[0];
  assign do_mod1_out  = q.do_drv[1];
  assign rio_out      = q.rio_drv;
  assign rio_out_stb  = q.rio_stb;
  assign outputs_live = run;
  assign irq          = |(q.irq_stat & q.irq_mask);
  assign alive_w      = q.alive;
  assign di0_w        = q.di[0];

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_init_sequence:
  assert property (@(posedge clk) disable iff (srst)
    (q.st == rhs_pkg::ST_CLR_FLT) |=> (q.st == rhs_pkg::ST_CLR_CTL)
      ##1 (q.st inside {rhs_pkg::ST_RUN_OK, rhs_pkg::ST_FAILED}))
  else $error("start-up did not reach run");

  a_fault_zeroed:
  assert property (@(posedge clk) disable iff (srst)
    (q.st == rhs_pkg::ST_CLR_FLT) |=> (q.irq_stat == '0 && q.diag == '0))
  else $error("fault registers not zeroed");

  a_cpu_report:
  assert property (@(posedge clk) disable iff (srst)
    (diag_on && cpu_fault) |=>
      (q.irq_stat[rhs_pkg::IRQ_CPU] && q.diag[rhs_pkg::ST_CPU]))
  else $error("cpu fault not reported");

  a_alive_step:
  assert property (@(posedge clk) disable iff (srst)
    (run && tick_if.tick) |=>
      (alive_w == (($past(alive_w) == rhs_pkg::ALIVE_WRAP) ? 8'h00
                   : $past(alive_w) + 8'h01)))
  else $error("alive counter step wrong");

  a_host_timeout:
  assert property (@(posedge clk) disable iff (srst)
    (run && tick_if.tick && !hb_chg && !cpu_fault &&
     q.tmo == rhs_pkg::HOST_TMO - 5'h01) |=>
      (q.offline && !do_mod0_out[0]))
  else $error("host offline not declared");

  a_contact_off:
  assert property (@(posedge clk) disable iff (srst)
    (q.offline || q.st != rhs_pkg::ST_RUN_OK) |-> !do_mod0_out[0])
  else $error("online contact closed while offline");

  a_wetting_sense:
  assert property (@(posedge clk) disable iff (srst)
    (diag_on && !di_in[0][0]) |=>
      (!q.diag[rhs_pkg::ST_WET] && q.irq_stat[rhs_pkg::IRQ_WET]))
  else $error("wetting loss not reported");

  a_fuse_alarm:
  assert property (@(posedge clk) disable iff (srst)
    (diag_on && |di_in[0][rhs_pkg::FUSE_N:1]) |=>
      q.irq_stat[rhs_pkg::IRQ_FUSE])
  else $error("fuse alarm not raised");

  a_outputs_quiet:
  assert property (@(posedge clk) disable iff (srst)
    (q.st != rhs_pkg::ST_RUN_OK) |-> (do_mod0_out == '0 &&
      do_mod1_out == '0 && rio_out == '0))
  else $error("output driven outside run");

  a_ctrl_cleared:
  assert property (@(posedge clk) disable iff (srst)
    (q.st == rhs_pkg::ST_CLR_CTL) |=> (q.do_w == '0 && q.gw_out == '0))
  else $error("control memory not cleared");

  a_scan_copy:
  assert property (@(posedge clk) disable iff (srst)
    diag_on |=> (di0_w == $past(di_in[0])))
  else $error("input scan copy missed");

endmodule

/* File: rhs_field_model.sv */
// Field-side model: local input modules, remote chassis, fault sources.
// Assumes the bench changes its values by NBA just after a clock edge.
`timescale 1ns/100ps
module rhs_field_model (
  input  wire logic             clk,
  input  wire logic [1:0][31:0] rio_out,
  input  wire logic [1:0]       rio_out_stb,
  output logic                  cpu_fault,
  output logic                  module_fault,
  output logic      [1:0]       rio_link_ok,
  output logic                  rio_redund_ok,
  output logic                  serial_link_ok,
  output logic      [3:0][31:0] di_in,
  output logic      [7:0][15:0] ai_in,
  output logic      [1:0][31:0] rio_in
);
  int          rx_cnt  = 0;
  logic [31:0] rx_word = 32'h0;

  initial begin
    cpu_fault      = 1'b0;
    module_fault   = 1'b1;
    rio_link_ok    = 2'h1;
    rio_redund_ok  = 1'b0;
    serial_link_ok = 1'b0;
    di_in          = '0;
    ai_in          = '0;
    ai_in[3]       = 16'h0abc;
    rio_in         = '0;
  end

  // Chassis takes a word only on the strobe, so repeats go unseen
  always @(posedge clk) begin
    if (rio_out_stb[0] === 1'b1) begin
      rx_cnt  <= rx_cnt + 1;
      rx_word <= rio_out[0];
    end
  end
endmodule

/* File: tb_rtu_health_supervisor.sv */
// Directed bench for the health supervisor over APB.
// Assumes a shortened second of TC cycles; host timeout is 30 of them.
`timescale 1ns/100ps
module tb_rtu_health_supervisor;
  localparam int TC = 20;
  logic             clk, srst, psel, penable, pwrite, pready, pslverr;
  logic             live, irq, err, cf, mf, rdn, ser;
  logic [11:0]      paddr;
  logic [31:0]      pwdata, prdata, rd, do0, do1, a0, ex;
  logic [1:0]       rlk, stb;
  logic [1:0][31:0] rio_out, rio_in;
  logic [3:0][31:0] di;
  logic [7:0][15:0] ai;
  int               error_cnt, total_checks, k;

  rhs_supervisor #(.TICK_CYC(TC)) uut (.clk(clk), .srst(srst),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cpu_fault(cf), .module_fault(mf), .rio_link_ok(rlk),
    .rio_redund_ok(rdn), .serial_link_ok(ser), .di_in(di), .ai_in(ai),
    .rio_in(rio_in), .do_mod0_out(do0), .do_mod1_out(do1),
    .rio_out(rio_out), .rio_out_stb(stb), .outputs_live(live), .irq(irq));

  rhs_field_model fld (.clk(clk), .rio_out(rio_out), .rio_out_stb(stb),
    .cpu_fault(cf), .module_fault(mf), .rio_link_ok(rlk),
    .rio_redund_ok(rdn), .serial_link_ok(ser), .di_in(di), .ai_in(ai),
    .rio_in(rio_in));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ****************************************************************
  // Bus and check tasks
  // ****************************************************************
  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Entered just after an edge; leaves the bus idle one cycle
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
    int n;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    psel    <= 1'b1;
    penable <= 1'b0;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      error_cnt++;
      print_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rdc(input string nm, input logic [11:0] a,
                     input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    error_cnt = 0;
    total_checks = 0;
    repeat (6) @(posedge clk);
    chk("do0 in reset", 32'h0, do0);
    srst <= 1'b0;
    @(posedge clk);
    #1 chk("live edge1", 32'h0, {31'h0, live});
    @(posedge clk);
    #1 chk("live edge2", 32'h1, {31'h0, live});
    @(posedge clk);
    rdc("alive start", rhs_pkg::A_ALIVE, 32'h0);
    for (int i = 0; i < 6; i++) begin
      fld.di_in[0] <= 32'h1 << i;
      repeat (2) @(posedge clk);
      ex = 32'h246 | ((i == 0) ? 32'h80 : 32'h0);
      ex = ex | ((i >= 1 && i <= 4) ? 32'h100 : 32'h0);
      rdc("status", rhs_pkg::A_STATUS, ex);
      rdc("di word", rhs_pkg::A_DI, 32'h1 << i);
    end
    fld.di_in[0] <= 32'h1;
    rdc("ai word", rhs_pkg::A_AI + 12'h00c, 32'h0abc);
    xfer(1'b0, rhs_pkg::A_ALIVE, 32'h0);
    a0 = rd;
    repeat (17) @(posedge clk);
    rdc("alive step", rhs_pkg::A_ALIVE, a0 + 32'h1);
    wr(rhs_pkg::A_DO, 32'hf0);
    @(posedge clk);
    chk("contact online", 32'hf1, do0);
    wr(rhs_pkg::A_DO + 12'h004, 32'h3c);
    chk("do1 word", 32'h3c, do1);
    wr(rhs_pkg::A_HOST_HB, 32'h5);
    repeat (9) begin
      wr(rhs_pkg::A_HOST_HB, 32'h5);
      repeat (57) @(posedge clk);
    end
    rdc("still online", rhs_pkg::A_STATUS, 32'h2c6);
    repeat (80) @(posedge clk);
    rdc("offline", rhs_pkg::A_STATUS, 32'h286);
    chk("contact open", 32'hf0, do0);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(rhs_pkg::A_IRQ_MASK, 32'h10);
    @(posedge clk);
    chk("irq raised", 32'h1, {31'h0, irq});
    wr(rhs_pkg::A_HOST_HB, 32'h6);
    wr(rhs_pkg::A_IRQ_STAT, 32'h7f);
    @(posedge clk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    rdc("irq stat", rhs_pkg::A_IRQ_STAT, 32'h0e);
    chk("contact back", 32'hf1, do0);
    wr(rhs_pkg::A_IRQ_MASK, 32'h0);
    fld.rio_in[1] <= 32'habc;
    fld.rio_link_ok <= 2'h3;
    repeat (2) @(posedge clk);
    rdc("rio in", rhs_pkg::A_RIO_IN + 12'h004, 32'habc);
    fld.rio_link_ok <= 2'h1;
    fld.rio_in[1] <= 32'h123;
    repeat (2) @(posedge clk);
    rdc("rio link down", rhs_pkg::A_RIO_IN + 12'h004, 32'habc);
    fld.module_fault <= 1'b0;
    fld.rio_link_ok <= 2'h3;
    fld.rio_redund_ok <= 1'b1;
    fld.serial_link_ok <= 1'b1;
    repeat (2) @(posedge clk);
    rdc("status healthy", rhs_pkg::A_STATUS, 32'h2fc);
    wr(rhs_pkg::A_IRQ_STAT, 32'h7f);
    rdc("irq healthy", rhs_pkg::A_IRQ_STAT, 32'h0);
    wr(rhs_pkg::A_RIO_OUT, 32'h55);
    wr(rhs_pkg::A_RIO_OUT, 32'h55);
    repeat (2) @(posedge clk);
    chk("rio strobes", 32'h1, fld.rx_cnt);
    chk("rio word", 32'h55, fld.rx_word);
    xfer(1'b0, rhs_pkg::A_CALC + 12'h050, 32'h0);
    chk("past calc err", 32'h1, {31'h0, err});
    chk("past calc data", 32'h0, rd);
    wr(rhs_pkg::A_CALC + 12'h04c, 32'h12345678);
    rdc("calc last", rhs_pkg::A_CALC + 12'h04c, 32'h12345678);
    wr(rhs_pkg::A_GW_IN, 32'hcafe);
    rdc("gw in", rhs_pkg::A_GW_IN, 32'hcafe);
    rdc("gw out apart", rhs_pkg::A_GW_OUT, 32'h0);
    wr(rhs_pkg::A_DI, 32'hffff);
    rdc("di read only", rhs_pkg::A_DI, 32'h1);
    k = 0;
    do begin
      xfer(1'b0, rhs_pkg::A_ALIVE, 32'h0);
      k++;
    end while (rd !== 32'hff && k < 3000);
    chk("alive reached", 32'hff, rd);
    repeat (17) @(posedge clk);
    rdc("alive wrap", rhs_pkg::A_ALIVE, 32'h0);
    fld.cpu_fault <= 1'b1;
    repeat (2) @(posedge clk);
    chk("failed contact", 32'h0, do0);
    chk("failed live", 32'h0, {31'h0, live});
    chk("failed rio", 32'h0, rio_out[0]);
    chk("failed do1", 32'h0, do1);
    xfer(1'b0, rhs_pkg::A_STATUS, 32'h0);
    chk("cpu fault bit", 32'h1, {31'h0, rd[0]});
    fld.cpu_fault <= 1'b0;
    srst <= 1'b1;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    repeat (3) @(posedge clk);
    rdc("do cleared", rhs_pkg::A_DO, 32'h0);
    rdc("alive rerun", rhs_pkg::A_ALIVE, 32'h0);
    chk("contact rerun", 32'h1, do0);
    chk("do1 rerun", 32'h0, do1);
    print_verdict();
  end
endmodule
